/* gpio_port_a_pkg.sv */
package gpio_port_a_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Port geometry and bus layout.
  localparam int          PORT_WIDTH    = 8;
  localparam int          ADDR_WIDTH    = 5;
  localparam int          DATA_WIDTH    = 32;

  // Register byte offsets.
  localparam logic [4:0]  OFS_PIN_LEVEL = 5'h00;
  localparam logic [4:0]  OFS_LATCH     = 5'h04;
  localparam logic [4:0]  OFS_DIRECTION = 5'h08;
  localparam logic [4:0]  OFS_CONV_CTL  = 5'h0c;
  localparam logic [4:0]  OFS_MODE_CTL  = 5'h10;

  // Field positions.
  localparam int          CFG_FIELD_LSB = 0;
  localparam int          CFG_FIELD_MSB = 3;
  localparam int          OSC_FIELD_LSB = 0;
  localparam int          OSC_FIELD_MSB = 3;
  localparam int          CREF_EN_BIT   = 4;

  // Pin positions with special behaviour.
  localparam int          PIN_REF_OUT   = 2;
  localparam int          PIN_FOUR      = 4;
  localparam int          PIN_SIX       = 6;
  localparam int          PIN_SEVEN     = 7;

  // Reset values and the analog channel limit.
  localparam logic [7:0]  RST_LATCH     = 8'h00;
  localparam logic [7:0]  RST_DIRECTION = 8'hff;
  localparam logic [3:0]  RST_CFG_FIELD = 4'h0;
  localparam logic [3:0]  RST_OSC_MODE  = 4'h7;
  localparam logic [7:0]  CHANNEL_LIMIT = 8'h0f;

  // Cycle clock is the core clock divided by this.
  localparam int          CYCLE_DIVIDE  = 4;
  localparam int          SYNC_STAGES   = 2;

  // Main oscillator modes.
  typedef enum logic [3:0] {
    OSC_LP, OSC_XT, OSC_HS, OSC_HS_PLL,
    OSC_RC_CLKOUT, RC_OSC_IO_MODE, OSC_EC_CLKOUT, EXT_CLOCK_IO_MODE,
    OSC_INT_CLKOUT, INTERNAL_OSC_IO_MODE
  } osc_mode_t;

  // One bus request as seen by the register file.
  typedef struct packed {
    logic [4:0]  address;
    logic        read;
    logic        write;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } bus_req_t;

  // Pin drive pair.
  typedef struct packed {
    logic [7:0] level;
    logic [7:0] enable;
  } pin_drive_t;

endpackage : gpio_port_a_pkg

/* gpio_port_a_with_latch.sv */
`timescale 1ns/1ps

module gpio_port_a_with_latch
  import gpio_port_a_pkg::*;
#(
  parameter int PINS = PORT_WIDTH
)(
  input  wire logic                  CORE_CLK,
  input  wire logic                  RESET,
  input  wire logic [ADDR_WIDTH-1:0] AVS_ADDRESS,
  input  wire logic                  AVS_READ,
  input  wire logic                  AVS_WRITE,
  input  wire logic [3:0]            AVS_BYTEENABLE,
  input  wire logic [DATA_WIDTH-1:0] AVS_WRITEDATA,
  output logic      [DATA_WIDTH-1:0] AVS_READDATA,
  output logic                       AVS_WAITREQUEST,
  input  wire logic [PINS-1:0]       PIN_IN,
  output logic      [PINS-1:0]       PIN_OUT,
  output logic      [PINS-1:0]       PIN_OE,
  output logic      [PINS-1:0]       ANALOG_PIN_SELECT,
  output logic                       TIMER_EXT_CLOCK_IN,
  output logic                       COMPARATOR_REF_OUTPUT,
  output logic      [3:0]            OSC_MODE,
  output logic                       CYCLE_CLOCK_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter check.
  if (PINS != PORT_WIDTH)
  begin : g_bad_width
    $error("Port width must be eight.");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers.

  // Analog channel mask for pins zero to three and five; channel n is analog below the limit.
  function automatic logic [7:0] analog_mask(input logic [3:0] field);
    logic [7:0] lim;
    logic [7:0] m;
    lim = CHANNEL_LIMIT - {4'h0, field};
    m   = 8'h00;
    if (8'h00 < lim)
      m[0] = 1'b1;
    if (8'h01 < lim)
      m[1] = 1'b1;
    if (8'h02 < lim)
      m[2] = 1'b1;
    if (8'h03 < lim)
      m[3] = 1'b1;
    if (8'h04 < lim)
      m[5] = 1'b1;
    return m;
  endfunction : analog_mask

  // Pin six is general-purpose only in the three IO modes.
  function automatic logic six_is_io(input logic [3:0] mode);
    return (mode == RC_OSC_IO_MODE) || (mode == INTERNAL_OSC_IO_MODE) ||
           (mode == EXT_CLOCK_IO_MODE);
  endfunction : six_is_io

  // Pin seven is general-purpose only with the internal oscillator.
  function automatic logic seven_is_io(input logic [3:0] mode);
    return (mode == INTERNAL_OSC_IO_MODE) || (mode == OSC_INT_CLKOUT);
  endfunction : seven_is_io

  ////////////////////////////////////////////////////////////////////////////
  // State.
  logic [7:0]  latch;
  logic [7:0]  direction;
  logic [3:0]  cfg_field;
  logic [3:0]  osc_mode;
  logic        cref_enable;
  logic [7:0]  sync_first;
  logic [7:0]  sync_second;
  logic [1:0]  div_count;
  bus_req_t    req;
  logic        bus_commit;
  logic        do_write;
  logic [7:0]  analog_sel;
  logic [7:0]  claimed;
  logic [7:0]  digital_in_ok;
  logic [7:0]  level_view;
  logic [31:0] next_readdata;
  pin_drive_t  next_drive;

  assign req        = '{address: AVS_ADDRESS, read: AVS_READ, write: AVS_WRITE,
                        byteenable: AVS_BYTEENABLE, writedata: AVS_WRITEDATA};
  assign bus_commit = (req.read || req.write) && !AVS_WAITREQUEST;
  assign do_write   = bus_commit && req.write && req.byteenable[0];

  ////////////////////////////////////////////////////////////////////////////
  // Pin ownership.
  always_comb
  begin
    analog_sel = analog_mask(cfg_field);
    claimed    = 8'h00;
    claimed[PIN_SIX]   = !six_is_io(osc_mode);
    claimed[PIN_SEVEN] = !seven_is_io(osc_mode);
    digital_in_ok = ~analog_sel & ~claimed;
    if (cref_enable)
      digital_in_ok[PIN_REF_OUT] = 1'b0;
    level_view = sync_second & digital_in_ok;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave handshake: one wait cycle per request.
  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
      AVS_WAITREQUEST <= 1'b1;
    else
      AVS_WAITREQUEST <= !((req.read || req.write) && AVS_WAITREQUEST);
  end

  always_comb
  begin
    next_readdata = 32'h0000_0000;
    if (req.address == OFS_PIN_LEVEL)
      next_readdata[7:0] = level_view & ~claimed;
    else if (req.address == OFS_LATCH)
      next_readdata[7:0] = latch & ~claimed;
    else if (req.address == OFS_DIRECTION)
      next_readdata[7:0] = direction & ~claimed;
    else if (req.address == OFS_CONV_CTL)
      next_readdata[CFG_FIELD_MSB:CFG_FIELD_LSB] = cfg_field;
    else if (req.address == OFS_MODE_CTL)
    begin
      next_readdata[OSC_FIELD_MSB:OSC_FIELD_LSB] = osc_mode;
      next_readdata[CREF_EN_BIT]                 = cref_enable;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
      AVS_READDATA <= 32'h0000_0000;
    else if (req.read && AVS_WAITREQUEST)
      AVS_READDATA <= next_readdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers written by software.
  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
      latch <= RST_LATCH;
    else if (do_write && (req.address == OFS_PIN_LEVEL || req.address == OFS_LATCH))
      latch <= req.writedata[7:0];
  end

  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
      direction <= RST_DIRECTION;
    else if (do_write && req.address == OFS_DIRECTION)
      direction <= req.writedata[7:0];
  end

  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
      cfg_field <= RST_CFG_FIELD;
    else if (do_write && req.address == OFS_CONV_CTL)
      cfg_field <= req.writedata[CFG_FIELD_MSB:CFG_FIELD_LSB];
  end

  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      osc_mode    <= RST_OSC_MODE;
      cref_enable <= 1'b0;
    end
    else if (do_write && req.address == OFS_MODE_CTL)
    begin
      osc_mode    <= req.writedata[OSC_FIELD_MSB:OSC_FIELD_LSB];
      cref_enable <= req.writedata[CREF_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchroniser.
  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      sync_first  <= 8'h00;
      sync_second <= 8'h00;
    end
    else
    begin
      sync_first  <= PIN_IN;
      sync_second <= sync_first;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle clock divider.
  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
      div_count <= 2'h0;
    else
      div_count <= div_count + 2'h1;
  end

  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
      CYCLE_CLOCK_OUT <= 1'b0;
    else
      CYCLE_CLOCK_OUT <= div_count[1];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers.
  always_comb
  begin
    next_drive.level  = latch;
    next_drive.enable = ~direction;
    next_drive.level[PIN_FOUR] = 1'b0;
    next_drive.enable[PIN_FOUR] = !direction[PIN_FOUR] && !latch[PIN_FOUR];
    if (cref_enable)
    begin
      next_drive.level[PIN_REF_OUT]  = 1'b0;
      next_drive.enable[PIN_REF_OUT] = 1'b0;
    end
    if (claimed[PIN_SIX])
    begin
      next_drive.level[PIN_SIX]  = div_count[1];
      next_drive.enable[PIN_SIX] = 1'b1;
    end
    if (claimed[PIN_SEVEN])
    begin
      next_drive.level[PIN_SEVEN]  = 1'b0;
      next_drive.enable[PIN_SEVEN] = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      PIN_OUT <= 8'h00;
      PIN_OE  <= 8'h00;
    end
    else
    begin
      PIN_OUT <= next_drive.level;
      PIN_OE  <= next_drive.enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Side-band outputs to the neighbouring units.
  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      TIMER_EXT_CLOCK_IN    <= 1'b0;
      ANALOG_PIN_SELECT     <= 8'h00;
      COMPARATOR_REF_OUTPUT <= 1'b0;
      OSC_MODE              <= RST_OSC_MODE;
    end
    else
    begin
      TIMER_EXT_CLOCK_IN    <= sync_second[PIN_FOUR];
      ANALOG_PIN_SELECT     <= analog_sel;
      COMPARATOR_REF_OUTPUT <= cref_enable;
      OSC_MODE              <= osc_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  AST_INPUT_OFF: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (direction[0] && !analog_sel[0]) |=> !PIN_OE[0])
    else $error("Pin zero driven while set as input.");

  AST_DRIVE_LATCH: assert property (@(posedge CORE_CLK) disable iff (RESET)
    !direction[1] |=> (PIN_OE[1] && PIN_OUT[1] == $past(latch[1])))
    else $error("Pin one does not drive its latch bit.");

  AST_LEVEL_READ: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (req.read && AVS_WAITREQUEST && req.address == OFS_PIN_LEVEL && !analog_sel[4])
    |=> AVS_READDATA[4] == $past(sync_second[4]))
    else $error("Pin level read does not return pin four.");

  AST_LATCH_WRITE: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (do_write && req.address == OFS_PIN_LEVEL) |=> latch == $past(req.writedata[7:0]))
    else $error("Write to pin level register missed the latch.");

  AST_CLAIMED_ZERO: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (req.read && AVS_WAITREQUEST && claimed[PIN_SEVEN]) |=> !AVS_READDATA[PIN_SEVEN])
    else $error("Claimed pin seven read as one.");

  AST_CYCLE_CLOCK: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (claimed[PIN_SIX] && $stable(claimed[PIN_SIX])) |=> PIN_OE[PIN_SIX])
    else $error("Pin six not driven by cycle clock.");

  AST_OPEN_DRAIN: assert property (@(posedge CORE_CLK) disable iff (RESET)
    PIN_OE[PIN_FOUR] |-> !PIN_OUT[PIN_FOUR])
    else $error("Pin four drove a high level.");

  AST_TIMER_ROUTE: assert property (@(posedge CORE_CLK) disable iff (RESET)
    $rose(PIN_IN[PIN_FOUR]) ##1 PIN_IN[PIN_FOUR] |-> ##2 TIMER_EXT_CLOCK_IN)
    else $error("Pin four not routed to timer clock.");

  AST_REF_PIN: assert property (@(posedge CORE_CLK) disable iff (RESET)
    cref_enable |=> !PIN_OE[PIN_REF_OUT])
    else $error("Pin two driven while reference output is on.");

  AST_ANALOG_READ: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (req.read && AVS_WAITREQUEST && req.address == OFS_PIN_LEVEL && analog_sel[0])
    |=> !AVS_READDATA[0])
    else $error("Analog pin zero read as one.");

  AST_ONE_WAIT: assert property (@(posedge CORE_CLK) disable iff (RESET)
    ((req.read || req.write) && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST)
    else $error("Request not answered after one wait cycle.");

  AST_WAIT_IDLE: assert property (@(posedge CORE_CLK) disable iff (RESET)
    !(req.read || req.write) |=> AVS_WAITREQUEST)
    else $error("Waitrequest low without a request.");

  AST_SEVEN_OFF: assert property (@(posedge CORE_CLK) disable iff (RESET)
    claimed[PIN_SEVEN] |=> !PIN_OE[PIN_SEVEN])
    else $error("Claimed pin seven still driven.");

  AST_SIX_LEVEL: assert property (@(posedge CORE_CLK) disable iff (RESET)
    claimed[PIN_SIX] |=> (PIN_OUT[PIN_SIX] == CYCLE_CLOCK_OUT))
    else $error("Pin six level differs from cycle clock.");

  AST_CYCLE_PERIOD: assert property (@(posedge CORE_CLK) disable iff (RESET)
    $changed(CYCLE_CLOCK_OUT) |=> $stable(CYCLE_CLOCK_OUT))
    else $error("Cycle clock phase shorter than two core cycles.");

  AST_LATCH_READ: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (req.read && AVS_WAITREQUEST && req.address == OFS_LATCH) |=> AVS_READDATA[5] == $past(latch[5]))
    else $error("Latch read does not return latch bit five.");

  AST_DIR_WRITE: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (do_write && req.address == OFS_DIRECTION) |=> direction == $past(req.writedata[7:0]))
    else $error("Write to direction register did not land.");

  AST_LANE_OFF: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (bus_commit && req.write && !req.byteenable[0]) |=> ($stable(latch) && $stable(direction)))
    else $error("Write with lane zero off changed a register.");

  AST_REF_READ: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (req.read && AVS_WAITREQUEST && req.address == OFS_PIN_LEVEL && cref_enable) |=> !AVS_READDATA[PIN_REF_OUT])
    else $error("Pin two read as one while reference output is on.");

  AST_READ_UPPER: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (req.read && AVS_WAITREQUEST) |=> (AVS_READDATA[31:8] == 24'h000000))
    else $error("Read data above bit seven not zero.");

endmodule : gpio_port_a_with_latch

/* pin_board_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Board side of the port pins: resolves each pad from all of its drivers.
module pin_board_model
  import gpio_port_a_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic [PORT_WIDTH-1:0] dut_out,
  input  wire logic [PORT_WIDTH-1:0] dut_oe,
  input  wire logic [PORT_WIDTH-1:0] drive_en,
  input  wire logic [PORT_WIDTH-1:0] drive_val,
  output logic      [PORT_WIDTH-1:0] wire_level
);
  logic [PORT_WIDTH-1:0] churn = 8'h00;
  // A floating pad other than pin four shows a pattern that changes every cycle.
  always @(posedge clk)
    churn <= ~churn;
  always_comb
  begin
    for (int i = 0; i < PORT_WIDTH; i++)
    begin
      if (dut_oe[i])
        wire_level[i] = dut_out[i];
      else if (drive_en[i])
        wire_level[i] = drive_val[i];
      else if (i == PIN_FOUR)
        wire_level[i] = 1'b1;
      else
        wire_level[i] = churn[i];
    end
  end
endmodule : pin_board_model

/* testbench.sv */
`timescale 1ns/1ps
module testbench
  import gpio_port_a_pkg::*;
;
  logic        CORE_CLK = 1'b0;
  logic        RESET = 1'b1;
  logic [4:0]  address = 5'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [3:0]  byteenable = 4'h0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [7:0]  pin_in, pin_out, pin_oe, analog_sel, drive_en = 8'hff, drive_val = 8'hff;
  logic        timer_in, cref_out, cycle_out;
  logic [3:0]  osc_mode;
  logic [7:0]  m_latch, m_dir;
  logic [3:0]  m_cfg, m_mode;
  logic        m_cref;
  logic [31:0] seed = 32'he8592f7b;
  logic [31:0] q;
  int          bad_count = 0;
  int          checks = 0;
  always #12.5 CORE_CLK = ~CORE_CLK;
  gpio_port_a_with_latch dut (.CORE_CLK(CORE_CLK), .RESET(RESET), .AVS_ADDRESS(address), .AVS_READ(read),
    .AVS_WRITE(write), .AVS_BYTEENABLE(byteenable), .AVS_WRITEDATA(writedata), .AVS_READDATA(readdata),
    .AVS_WAITREQUEST(waitrequest), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
    .ANALOG_PIN_SELECT(analog_sel), .TIMER_EXT_CLOCK_IN(timer_in), .COMPARATOR_REF_OUTPUT(cref_out),
    .OSC_MODE(osc_mode), .CYCLE_CLOCK_OUT(cycle_out));
  pin_board_model board (.clk(CORE_CLK), .dut_out(pin_out), .dut_oe(pin_oe), .drive_en(drive_en),
    .drive_val(drive_val), .wire_level(pin_in));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  function automatic logic [7:0] analog_mask(input logic [3:0] cfg);
    logic [7:0] m;
    m = 8'h00;
    for (int n = 0; n < 5; n++)
      if (n < 15 - int'(cfg))
        m[(n == 4) ? 5 : n] = 1'b1;
    return m;
  endfunction : analog_mask
  function automatic logic [7:0] claim_mask(input logic [3:0] mode);
    logic [7:0] m;
    m = 8'h00;
    m[6] = !(mode == 4'h5 || mode == 4'h7 || mode == 4'h9);
    m[7] = !(mode == 4'h8 || mode == 4'h9);
    return m;
  endfunction : claim_mask
  //////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  task automatic compare(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : compare
  // Request rises after an edge and is held until waitrequest is seen low at a rising edge.
  task automatic bus_cycle(input logic [4:0] a, input logic wr, input logic [31:0] d, input logic [3:0] be,
                           output logic [31:0] r);
    int n;
    @(posedge CORE_CLK);
    address <= a;
    writedata <= d;
    byteenable <= be;
    read <= !wr;
    write <= wr;
    n = 0;
    do
    begin
      @(posedge CORE_CLK);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 40);
    compare("bus answer", n < 40, 1'b1);
    r = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus_cycle
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus_cycle(a, 1'b1, {24'h0, d}, 4'h1, r);
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [31:0] r);
    bus_cycle(a, 1'b0, 32'h0, 4'h1, r);
  endtask : rd
  task automatic check_all();
    logic [7:0] an, cl, vis, oe, known, wire_e, lv;
    logic [31:0] r;
    int ones, six;
    an = analog_mask(m_cfg);
    cl = claim_mask(m_mode);
    oe = ~m_dir;
    oe[4] = ~m_dir[4] & ~m_latch[4];
    oe[2] = oe[2] & ~m_cref;
    oe[6] = oe[6] | cl[6];
    oe[7] = oe[7] & ~cl[7];
    repeat (6) @(negedge CORE_CLK);
    compare("drive enable", pin_oe, oe);
    compare("drive level", pin_out & oe & 8'hbf, m_latch & oe & 8'haf);
    compare("analog select", analog_sel, an);
    compare("osc mode", osc_mode, m_mode);
    compare("ref out", cref_out, m_cref);
    wire_e = (m_latch & 8'hef & oe) | (drive_val & drive_en & ~oe) | (8'h10 & ~oe & ~drive_en);
    known = oe | drive_en | 8'h10;
    vis = ~an & ~cl & ~{5'h0, m_cref, 2'h0};
    lv = ~(vis & ~known);
    compare("timer in", timer_in, wire_e[4]);
    rd(OFS_PIN_LEVEL, r);
    compare("level", r & {24'hffffff, lv}, {24'h0, wire_e & vis & lv});
    rd(OFS_LATCH, r);
    compare("latch", r, {24'h0, m_latch & ~cl});
    rd(OFS_DIRECTION, r);
    compare("direction", r, {24'h0, m_dir & ~cl});
    rd(OFS_MODE_CTL, r);
    compare("mode register", r, {27'h0, m_cref, m_mode});
    rd(OFS_CONV_CTL, r);
    compare("analog field", r, {28'h0, m_cfg});
    if (cl[6])
    begin
      ones = 0;
      six = 0;
      repeat (8)
      begin
        @(negedge CORE_CLK);
        ones += cycle_out;
        six += pin_out[6];
      end
      compare("cycle clock duty", ones, 4);
      compare("pin six clock", six, 4);
    end
  endtask : check_all
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge CORE_CLK);
    bad_count++;
    complete_run();
  end
  initial
  begin
    repeat (12) @(posedge CORE_CLK);
    RESET <= 1'b0;
    m_latch = RST_LATCH;
    m_dir = RST_DIRECTION;
    m_cfg = RST_CFG_FIELD;
    m_mode = RST_OSC_MODE;
    m_cref = 1'b0;
    check_all();
    rd(OFS_CONV_CTL, q);
    compare("reset field", q, 32'h0);
    $display("test reset done");
    wr(5'h14, 8'h5a);
    rd(5'h14, q);
    compare("unmapped", q, 32'h0);
    bus_cycle(OFS_LATCH, 1'b1, 32'hff, 4'h0, q);
    rd(OFS_LATCH, q);
    compare("lane off write", q, 32'h0);
    $display("test refused done");
    wr(OFS_MODE_CTL, 8'h09);
    wr(OFS_CONV_CTL, 8'h0f);
    wr(OFS_DIRECTION, 8'h00);
    wr(OFS_LATCH, 8'h08);
    @(negedge CORE_CLK);
    compare("pin before", pin_out[3], 1'b0);
    @(negedge CORE_CLK);
    compare("pin after", pin_out[3], 1'b1);
    $display("test timing done");
    for (int k = 0; k < 24; k++)
    begin
      seed = lfsr_next(seed);
      m_mode = 4'(seed[15:0] % 10);
      m_cfg = seed[19:16];
      m_cref = seed[20];
      seed = lfsr_next(seed);
      m_latch = seed[7:0];
      m_dir = seed[15:8] | analog_mask(m_cfg);
      @(posedge CORE_CLK);
      drive_en <= seed[23:16];
      drive_val <= seed[31:24];
      wr(OFS_MODE_CTL, {3'h0, m_cref, m_mode});
      wr(OFS_CONV_CTL, {4'h0, m_cfg});
      wr(k[0] ? OFS_PIN_LEVEL : OFS_LATCH, m_latch);
      wr(OFS_DIRECTION, m_dir);
      check_all();
    end
    $display("test random done");
    complete_run();
  end
endmodule : testbench
